// ---- rtl/rdcfg_pkg.sv ----
// constants for the relay driver configuration register bank
package rdcfg_pkg;
  localparam int unsigned CLK_HZ        = 50_000_000;
  localparam int unsigned CHANNELS      = 8;
  localparam logic [4:0]  ADDR_IDENTITY = 5'h00;
  localparam logic [4:0]  ADDR_OUT_SIDE = 5'h01;
  localparam logic [4:0]  ADDR_MODE     = 5'h02;
  localparam logic [4:0]  ADDR_PWM_FREQ = 5'h03;
  localparam logic [4:0]  ADDR_INRUSH   = 5'h04;
  localparam logic [4:0]  ADDR_RESERVED = 5'h05;
  localparam logic [4:0]  ADDR_OUT_ON   = 5'h06;
  localparam logic [4:0]  ADDR_IN0_MAP  = 5'h07;
  localparam logic [4:0]  ADDR_IN1_MAP  = 5'h08;
  localparam logic [4:0]  ADDR_GEN_MAP  = 5'h09;
  localparam logic [4:0]  ADDR_GEN_SEL  = 5'h0A;
  // identity value is arbitrary
  localparam logic [7:0]  IDENTITY_VAL  = 8'h5C;
  // reset values
  localparam logic [7:0]  RST_ZERO      = 8'h00;
  localparam logic [7:0]  RST_IN0_MAP   = 8'h04;
  localparam logic [7:0]  RST_IN1_MAP   = 8'h08;
  // field positions
  localparam int unsigned SIDE_LSB      = 2;
  localparam int unsigned DIS_UNMASK_B  = 1;
  localparam int unsigned RES_UNMASK_B  = 0;
  localparam int unsigned SOFT_RST_B    = 7;
  localparam int unsigned ACT_HOLD_B    = 6;
  localparam int unsigned LED_DIV_LSB   = 0;
  localparam int unsigned GEN_DIV_LSB   = 0;
  localparam int unsigned TRIM_LSB      = 2;
  // frame layout
  localparam int unsigned FRAME_BITS    = 16;
  localparam int unsigned FR_RW_B       = 15;
  localparam int unsigned FR_ADDR_LSB   = 10;
  localparam int unsigned FR_DATA_LSB   = 2;
  localparam int unsigned FR_PAR_B      = 1;
  localparam int unsigned FR_TOG_B      = 0;
  // pwm base ramp step in clocks, 1/256 of the 122.5 Hz period; each divider step halves it again
  localparam int unsigned PWM_BASE_MHZ  = 122_500;
  localparam int unsigned PWM_BASE_CYC  = (CLK_HZ / PWM_BASE_MHZ) * 1000 / 256;
  localparam logic [1:0]  TRIM_DOWN     = 2'h1;
  localparam logic [1:0]  TRIM_UP       = 2'h2;
  localparam int unsigned TRIM_PCT      = 15;
  localparam int unsigned PCT_FULL      = 100;
endpackage

// ---- rtl/rdcfg_general_pwm_source.sv ----
// pwm generator: 256-step ramp at a selectable, trimmed rate
`timescale 1ns/1ns
module rdcfg_general_pwm_source
  import rdcfg_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       sync_clr,
  // settings
  input  wire logic [1:0] freq_sel,
  input  wire logic [1:0] freq_trim,
  input  wire logic [7:0] duty,
  // output
  output logic            pwm_q
);
  localparam logic [15:0] BASE  = 16'(PWM_BASE_CYC);
  localparam logic [15:0] DOWN  = 16'(PWM_BASE_CYC * PCT_FULL / (PCT_FULL - TRIM_PCT));
  localparam logic [15:0] UP    = 16'(PWM_BASE_CYC * PCT_FULL / (PCT_FULL + TRIM_PCT));

  logic [15:0] step_len;
  logic [15:0] div_q;
  logic [7:0]  ramp_q;
  logic        tick;

  // step length: slower trim stretches the step, faster shortens it
  always_comb begin
    unique case (freq_trim)
      TRIM_DOWN: step_len = DOWN >> freq_sel;
      TRIM_UP:   step_len = UP >> freq_sel;
      default:   step_len = BASE >> freq_sel;
    endcase
  end

  assign tick = (div_q >= step_len - 16'h0001);

  // prescaler yields one enable pulse per ramp step
  always_ff @(posedge clk) begin
    if (!rst_n || sync_clr || tick) begin
      div_q <= 16'h0000;
    end else begin
      div_q <= div_q + 16'h0001;
    end
  end

  // ramp counter, wraps every 256 steps
  always_ff @(posedge clk) begin
    if (!rst_n || sync_clr) begin
      ramp_q <= 8'h00;
    end else if (tick) begin
      ramp_q <= ramp_q + 8'h01;
    end
  end

  // compare; 0xFF duty means fully on
  always_ff @(posedge clk) begin
    if (!rst_n || sync_clr) begin
      pwm_q <= 1'b0;
    end else begin
      pwm_q <= (duty == 8'hFF) || (ramp_q < duty);
    end
  end
endmodule // rdcfg_general_pwm_source

// ---- rtl/rdcfg_regs.sv ----
// spi-reached configuration register bank for an eight-channel relay driver
`timescale 1ns/1ns
module rdcfg_regs
  import rdcfg_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // serial link, sampled on clk
  input  wire logic        spi_cs_n,
  input  wire logic        spi_sck,
  input  wire logic        spi_mosi,
  output logic             spi_miso,
  output logic             spi_miso_oe,
  // pins and supply
  input  wire logic        ext_reset_pin_n,
  input  wire logic        ext_disable_pin,
  input  wire logic        digital_supply_undervoltage,
  input  wire logic        direct_input_a,
  input  wire logic        direct_input_b,
  // duty settings from the registers beyond this bank
  input  wire logic [7:0]  main_gen_duty,
  input  wire logic [7:0]  led_gen_duty,
  // outputs to the drivers
  output logic [7:0]       channel_on_q,
  output logic [7:0]       high_side_q,
  output logic [7:0]       bulb_inrush_q,
  output logic             active_mode_q,
  output logic             disable_active_q
);
  typedef enum logic [1:0] {RDCFG_IDLE, RDCFG_SHIFT, RDCFG_DONE} rdcfg_state_t;

  rdcfg_state_t state_q;
  logic [7:0]  side_cfg_q;
  logic [7:0]  mode_q;
  logic [7:0]  freq_q;
  logic [7:0]  inrush_q;
  logic [7:0]  out_on_q;
  logic [7:0]  in0_map_q;
  logic [7:0]  in1_map_q;
  logic [7:0]  gen_map_q;
  logic [7:0]  gen_sel_q;
  logic [15:0] rx_q;
  logic [15:0] tx_q;
  logic [4:0]  bit_cnt_q;
  logic        sck_prev_q;
  logic        cs_prev_q;
  logic        err_q;
  logic        soft_rst_q;
  logic        cfg_clr;
  logic        frame_end;
  logic        frame_ok;
  logic        wr_en;
  logic [4:0]  rx_addr;
  logic [7:0]  rx_data;
  logic [7:0]  rd_data;
  logic [15:0] tx_frame;
  logic        main_pwm;
  logic        led_pwm;

  // every source of reset returns the configuration to defaults
  assign cfg_clr = !rst_n || soft_rst_q || digital_supply_undervoltage ||
                   (side_cfg_q[RES_UNMASK_B] && !ext_reset_pin_n);

  // frame decode, command word shaped as sent by the master
  assign rx_addr   = rx_q[FR_ADDR_LSB +: 5];
  assign rx_data   = rx_q[FR_DATA_LSB +: 8];
  assign frame_end = cs_prev_q == 1'b0 && spi_cs_n == 1'b1;
  // short or long frames and even parity are rejected
  assign frame_ok  = (bit_cnt_q == 5'(FRAME_BITS)) && (^rx_q[FR_RW_B:FR_PAR_B]);
  assign wr_en     = frame_end && frame_ok && rx_q[FR_RW_B];

  // edge history of the link pins
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sck_prev_q <= 1'b0;
      cs_prev_q  <= 1'b1;
    end else begin
      sck_prev_q <= spi_sck;
      cs_prev_q  <= spi_cs_n;
    end
  end

  // frame state: idle, shifting, answered
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= RDCFG_IDLE;
    end else begin
      unique case (state_q)
        RDCFG_IDLE:  if (!spi_cs_n) state_q <= RDCFG_SHIFT;
        RDCFG_SHIFT: if (frame_end) state_q <= RDCFG_DONE;
        RDCFG_DONE:  state_q <= RDCFG_IDLE;
      endcase
    end
  end

  // receive shift on rising sck, mode 0
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_q      <= 16'h0000;
      bit_cnt_q <= 5'h00;
    end else if (state_q == RDCFG_IDLE) begin
      bit_cnt_q <= 5'h00;
    end else if (!spi_cs_n && spi_sck && !sck_prev_q) begin
      rx_q <= {rx_q[14:0], spi_mosi};
      if (bit_cnt_q != 5'h1F) begin
        bit_cnt_q <= bit_cnt_q + 5'h01;
      end
    end
  end

  // error flag reported in the next answer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      err_q <= 1'b0;
    end else if (frame_end) begin
      err_q <= !frame_ok;
    end
  end

  // read mux; reserved space and unmapped offsets read zero
  always_comb begin
    unique case (rx_addr)
      ADDR_IDENTITY: rd_data = IDENTITY_VAL;
      ADDR_OUT_SIDE: rd_data = side_cfg_q;
      ADDR_MODE:     rd_data = {1'b0, mode_q[6:0]};
      ADDR_PWM_FREQ: rd_data = freq_q;
      ADDR_INRUSH:   rd_data = inrush_q;
      ADDR_OUT_ON:   rd_data = out_on_q;
      ADDR_IN0_MAP:  rd_data = in0_map_q;
      ADDR_IN1_MAP:  rd_data = in1_map_q;
      ADDR_GEN_MAP:  rd_data = gen_map_q;
      ADDR_GEN_SEL:  rd_data = gen_sel_q;
      default:       rd_data = RST_ZERO;
    endcase
  end

  // answer: error, address echo, data, odd parity, toggle echo
  always_comb begin
    tx_frame = {err_q, rx_addr, rd_data, 1'b0, rx_q[FR_TOG_B]};
    tx_frame[FR_PAR_B] = ~^tx_frame[FR_RW_B:FR_DATA_LSB];
  end

  // answer loads one clock after frame end, so its error bit is this frame's
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_q <= 16'h0000;
    end else if (state_q == RDCFG_DONE) begin
      tx_q <= tx_frame;
    end else if (!spi_cs_n && !spi_sck && sck_prev_q) begin
      tx_q <= {tx_q[14:0], 1'b0};
    end
  end

  // miso drives only while selected
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      spi_miso    <= 1'b0;
      spi_miso_oe <= 1'b0;
    end else begin
      spi_miso    <= tx_q[FRAME_BITS-1];
      spi_miso_oe <= !spi_cs_n;
    end
  end

  // soft reset pulse: one cycle, then clears itself
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      soft_rst_q <= 1'b0;
    end else begin
      soft_rst_q <= wr_en && rx_addr == ADDR_MODE && rx_data[SOFT_RST_B];
    end
  end

  // side, pin masks
  always_ff @(posedge clk) begin
    if (cfg_clr) begin
      side_cfg_q <= RST_ZERO;
    end else if (wr_en && rx_addr == ADDR_OUT_SIDE) begin
      side_cfg_q <= rx_data;
    end
  end

  // mode: active hold and led divider; reset bit not stored
  always_ff @(posedge clk) begin
    if (cfg_clr) begin
      mode_q <= RST_ZERO;
    end else if (wr_en && rx_addr == ADDR_MODE) begin
      mode_q <= {1'b0, rx_data[ACT_HOLD_B], 4'h0, rx_data[LED_DIV_LSB +: 2]};
    end
  end

  // main divider and trim; upper nibble unused
  always_ff @(posedge clk) begin
    if (cfg_clr) begin
      freq_q <= RST_ZERO;
    end else if (wr_en && rx_addr == ADDR_PWM_FREQ) begin
      freq_q <= {4'h0, rx_data[TRIM_LSB +: 2], rx_data[GEN_DIV_LSB +: 2]};
    end
  end

  // bulb inrush enables, channel 7 at the msb
  always_ff @(posedge clk) begin
    if (cfg_clr) begin
      inrush_q <= RST_ZERO;
    end else if (wr_en && rx_addr == ADDR_INRUSH) begin
      inrush_q <= rx_data;
    end
  end

  // direct on/off bits, one per channel
  always_ff @(posedge clk) begin
    if (cfg_clr) begin
      out_on_q <= RST_ZERO;
    end else if (wr_en && rx_addr == ADDR_OUT_ON) begin
      out_on_q <= rx_data;
    end
  end

  // first parallel input routing; channel 2 by default
  always_ff @(posedge clk) begin
    if (cfg_clr) begin
      in0_map_q <= RST_IN0_MAP;
    end else if (wr_en && rx_addr == ADDR_IN0_MAP) begin
      in0_map_q <= rx_data;
    end
  end

  // second parallel input routing; channel 3 by default
  always_ff @(posedge clk) begin
    if (cfg_clr) begin
      in1_map_q <= RST_IN1_MAP;
    end else if (wr_en && rx_addr == ADDR_IN1_MAP) begin
      in1_map_q <= rx_data;
    end
  end

  // generator routing, none by default
  always_ff @(posedge clk) begin
    if (cfg_clr) begin
      gen_map_q <= RST_ZERO;
    end else if (wr_en && rx_addr == ADDR_GEN_MAP) begin
      gen_map_q <= rx_data;
    end
  end

  // generator choice per channel; kept here since routing needs it
  always_ff @(posedge clk) begin
    if (cfg_clr) begin
      gen_sel_q <= RST_ZERO;
    end else if (wr_en && rx_addr == ADDR_GEN_SEL) begin
      gen_sel_q <= rx_data;
    end
  end

  // two generators share one module; cleared with the config
  rdcfg_general_pwm_source u_main_gen (
    .clk       (clk),
    .rst_n     (rst_n),
    .sync_clr  (cfg_clr),
    .freq_sel  (freq_q[GEN_DIV_LSB +: 2]),
    .freq_trim (freq_q[TRIM_LSB +: 2]),
    .duty      (main_gen_duty),
    .pwm_q     (main_pwm)
  );

  rdcfg_general_pwm_source u_led_gen (
    .clk       (clk),
    .rst_n     (rst_n),
    .sync_clr  (cfg_clr),
    .freq_sel  (mode_q[LED_DIV_LSB +: 2]),
    .freq_trim (freq_q[TRIM_LSB +: 2]),
    .duty      (led_gen_duty),
    .pwm_q     (led_pwm)
  );

  // channel drive: or of all routed sources, gated by disable
  generate
    for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          channel_on_q[ch] <= 1'b0;
        end else begin
          channel_on_q[ch] <= !(side_cfg_q[DIS_UNMASK_B] && ext_disable_pin) &&
                              (out_on_q[ch] || (in0_map_q[ch] && direct_input_a) ||
                               (in1_map_q[ch] && direct_input_b) ||
                               (gen_map_q[ch] && (gen_sel_q[ch] ? led_pwm : main_pwm)));
        end
      end
    end
  endgenerate

  // side outputs; channels 0 and 1 are high side whenever out of reset, reset loads all low
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      high_side_q <= RST_ZERO;
    end else begin
      high_side_q <= {side_cfg_q[7:SIDE_LSB], 2'b11};
    end
  end

  // inrush enables out to the drivers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bulb_inrush_q <= RST_ZERO;
    end else begin
      bulb_inrush_q <= inrush_q;
    end
  end

  // active hold out to the mode logic
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      active_mode_q <= 1'b0;
    end else begin
      active_mode_q <= mode_q[ACT_HOLD_B];
    end
  end

  // disable pin as seen through its unmask bit; same edge as channel gating
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      disable_active_q <= 1'b0;
    end else begin
      disable_active_q <= side_cfg_q[DIS_UNMASK_B] && ext_disable_pin;
    end
  end
endmodule // rdcfg_regs

// ---- test/rdcfg_spi_master.sv ----
// spi master model driving mode 0 frames into the register bank
`timescale 1ns/1ns
module rdcfg_spi_master (
  // clock
  input  wire logic clk,
  // serial link
  output logic      cs_n,
  output logic      sck,
  output logic      mosi,
  input  wire logic miso
);
  logic tog = 1'b0;

  // idle: deselected, serial clock parked low
  initial begin
    cs_n = 1'b1;
    sck  = 1'b0;
    mosi = 1'b0;
  end

  // n bits, msb first; fewer than 16 makes a short frame; long high phase
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx, input int n);
    @(negedge clk);
    cs_n  = 1'b0;
    tx[0] = tog;
    tog   = ~tog;
    for (int i = 15; i > 15 - n; i--) begin
      mosi = tx[i];
      repeat (3) @(negedge clk);
      sck = 1'b1;
      repeat (5) @(negedge clk);
      rx[i] = miso;
      sck   = 1'b0;
    end
    repeat (3) @(negedge clk);
    cs_n = 1'b1;
    mosi = ~mosi; // no stale bit left on the line
    repeat (4) @(negedge clk);
  endtask
endmodule // rdcfg_spi_master

// ---- test/rdcfg_regs_sva.sv ----
// port-level checker for the configuration register bank
`timescale 1ns/1ns
module rdcfg_regs_sva (
  // clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  // serial link
  input wire logic       spi_cs_n,
  input wire logic       spi_sck,
  input wire logic       spi_miso,
  input wire logic       spi_miso_oe,
  // pins
  input wire logic       ext_reset_pin_n,
  input wire logic       ext_disable_pin,
  input wire logic       digital_supply_undervoltage,
  input wire logic       direct_input_a,
  input wire logic       direct_input_b,
  // outputs
  input wire logic [7:0] channel_on_q,
  input wire logic [7:0] high_side_q,
  input wire logic [7:0] bulb_inrush_q,
  input wire logic       active_mode_q,
  input wire logic       disable_active_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_oe_follow;
    $past(rst_n) |-> spi_miso_oe == !$past(spi_cs_n);
  endproperty
  a_oe_follow: assert property (p_oe_follow)
    else $error("miso enable not one clock behind select");

  property p_side_low;
    $past(rst_n) |-> high_side_q[1:0] == 2'b11;
  endproperty
  a_side_low: assert property (p_side_low)
    else $error("fixed channels not high side");

  property p_uv_clear;
    digital_supply_undervoltage [*3] |-> bulb_inrush_q == 8'h00 && high_side_q == 8'h03;
  endproperty
  a_uv_clear: assert property (p_uv_clear)
    else $error("undervoltage left config set");

  property p_uv_mode;
    digital_supply_undervoltage [*3] |-> !active_mode_q && !disable_active_q;
  endproperty
  a_uv_mode: assert property (p_uv_mode)
    else $error("undervoltage left mode set");

  property p_dis_mask;
    !ext_disable_pin [*3] |-> !disable_active_q;
  endproperty
  a_dis_mask: assert property (p_dis_mask)
    else $error("disable active without pin");

  property p_dis_off;
    disable_active_q |-> channel_on_q == 8'h00;
  endproperty
  a_dis_off: assert property (p_dis_off)
    else $error("channel driven while disabled");

  // config only moves at frame end, so a long selected span holds it
  property p_cfg_hold;
    (!spi_cs_n && ext_reset_pin_n && !digital_supply_undervoltage) [*4] |=>
      $stable(bulb_inrush_q) && $stable(active_mode_q) && $stable(high_side_q);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold)
    else $error("config changed inside a frame");

  property p_miso_hold;
    (spi_sck && spi_miso_oe) [*5] |-> $stable(spi_miso);
  endproperty
  a_miso_hold: assert property (p_miso_hold)
    else $error("miso moved while serial clock high");

  property p_uv_map;
    (digital_supply_undervoltage && $stable(direct_input_a) && $stable(direct_input_b)) [*4]
      |-> channel_on_q == {4'h0, direct_input_b, direct_input_a, 2'b00};
  endproperty
  a_uv_map: assert property (p_uv_map)
    else $error("default input routing wrong");

  c_frame: cover property ($rose(spi_cs_n));
  c_act:   cover property ($rose(active_mode_q));
  c_dis:   cover property ($rose(disable_active_q));
endmodule // rdcfg_regs_sva

bind rdcfg_regs rdcfg_regs_sva u_sva (
  .clk(clk), .rst_n(rst_n), .spi_cs_n(spi_cs_n), .spi_sck(spi_sck),
  .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .ext_reset_pin_n(ext_reset_pin_n),
  .ext_disable_pin(ext_disable_pin), .digital_supply_undervoltage(digital_supply_undervoltage),
  .direct_input_a(direct_input_a), .direct_input_b(direct_input_b),
  .channel_on_q(channel_on_q), .high_side_q(high_side_q), .bulb_inrush_q(bulb_inrush_q),
  .active_mode_q(active_mode_q), .disable_active_q(disable_active_q)
);

// ---- test/relay_driver_config_regs_tb_top.sv ----
// self-checking bench for the relay driver configuration bank
`timescale 1ns/1ns
module relay_driver_config_regs_tb_top;
  import rdcfg_pkg::*;
  logic       clk = 1'b0, rst_n = 1'b0, rpin_n = 1'b1, dpin = 1'b0, uv = 1'b0;
  logic       in_a = 1'b0, in_b = 1'b0, cs_n, sck, mosi, miso, miso_oe, act, dis;
  logic [7:0] chan, hside, inrush;
  logic [7:0] mduty = 8'h00, lduty = 8'h00;
  logic [15:0] rx;
  int         bad_count = 0;
  int         n_compared = 0;
  logic [7:0] dflt [10] = '{IDENTITY_VAL, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                            8'h04, 8'h08, 8'h00};
  logic [7:0] wv [10] = '{8'hA5, 8'h84, 8'h7F, 8'hFF, 8'h96, 8'hFF, 8'h81, 8'h10, 8'h20,
                          8'h00};
  logic [7:0] ev [10] = '{IDENTITY_VAL, 8'h84, 8'h43, 8'h0F, 8'h96, 8'h00, 8'h81, 8'h10,
                          8'h20, 8'h00};

  always #10 clk = ~clk;

  // duty only off or full on: a ramp period runs far past this run
  rdcfg_regs dut (
    .clk(clk), .rst_n(rst_n), .spi_cs_n(cs_n), .spi_sck(sck), .spi_mosi(mosi),
    .spi_miso(miso), .spi_miso_oe(miso_oe), .ext_reset_pin_n(rpin_n),
    .ext_disable_pin(dpin), .digital_supply_undervoltage(uv), .direct_input_a(in_a),
    .direct_input_b(in_b), .main_gen_duty(mduty), .led_gen_duty(lduty),
    .channel_on_q(chan), .high_side_q(hside), .bulb_inrush_q(inrush),
    .active_mode_q(act), .disable_active_q(dis)
  );
  // released miso shows the inverse of its last bit
  rdcfg_spi_master m (.clk(clk), .cs_n(cs_n), .sck(sck), .mosi(mosi),
                      .miso(miso_oe ? miso : !miso));

  function automatic logic [15:0] fr(input logic w, input logic [4:0] a, input logic [7:0] d);
    logic [15:0] f;
    f    = {w, a, d, 2'b00};
    f[1] = ~^f[15:2];
    return f;
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    m.xfer(fr(1'b1, a, d), rx, 16);
  endtask

  // answer of a read arrives in the following frame
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    m.xfer(fr(1'b0, a, 8'h00), rx, 16);
    m.xfer(fr(1'b0, ADDR_IDENTITY, 8'h00), rx, 16);
    chk(rx[9:2], e);
    chk({3'h0, rx[14:10]}, {3'h0, a});
    chk({7'h00, ^rx[15:1]}, 8'h01);
  endtask

  task automatic pause;
    repeat (4) @(negedge clk);
  endtask

  task automatic finish_test;
    $display("compared=%0d mismatches=%0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // watchdog well beyond the ~10.4k clocks the tests need
  initial begin
    repeat (60000) @(posedge clk);
    bad_count++;
    finish_test();
  end

  initial begin
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    pause();
    chk(hside, 8'h03);
    chk(inrush, 8'h00);
    chk(chan, 8'h00);
    for (int i = 0; i < 10; i++) rd(5'(i), dflt[i]);
    $display("test defaults done");
    for (int i = 0; i < 10; i++) wr(5'(i), wv[i]);
    for (int i = 0; i < 10; i++) rd(5'(i), ev[i]);
    chk(hside, 8'h87);
    chk(inrush, 8'h96);
    chk({7'h00, act}, 8'h01);
    chk(chan, 8'h81);
    in_a = 1'b1;
    pause();
    chk(chan, 8'h91);
    in_b = 1'b1;
    pause();
    chk(chan, 8'hB1);
    $display("test write readback done");
    dpin = 1'b1;
    pause();
    chk({7'h00, dis}, 8'h00);
    wr(ADDR_OUT_SIDE, 8'h86);
    chk({7'h00, dis}, 8'h01);
    chk(chan, 8'h00);
    dpin   = 1'b0;
    rpin_n = 1'b0;
    pause();
    chk(inrush, 8'h96);
    rpin_n = 1'b1;
    wr(ADDR_OUT_SIDE, 8'h87);
    rpin_n = 1'b0;
    pause();
    chk(inrush, 8'h00);
    chk(hside, 8'h03);
    rpin_n = 1'b1;
    rd(ADDR_OUT_SIDE, 8'h00);
    $display("test pins done");
    wr(ADDR_INRUSH, 8'h55);
    wr(ADDR_IN0_MAP, 8'h01);
    wr(ADDR_MODE, 8'h40);
    chk({7'h00, act}, 8'h01);
    wr(ADDR_MODE, 8'h80);
    chk({7'h00, act}, 8'h00);
    rd(ADDR_MODE, 8'h00);
    rd(ADDR_INRUSH, 8'h00);
    rd(ADDR_IN0_MAP, 8'h04);
    $display("test soft reset done");
    wr(ADDR_INRUSH, 8'h33);
    uv = 1'b1;
    repeat (6) @(negedge clk);
    chk(inrush, 8'h00);
    chk(chan, 8'h0C);
    uv = 1'b0;
    rd(ADDR_INRUSH, 8'h00);
    $display("test undervoltage done");
    mduty = 8'hFF;
    wr(ADDR_GEN_MAP, 8'h40);
    chk(chan, 8'h4C);
    wr(ADDR_GEN_SEL, 8'h40);
    chk(chan, 8'h0C);
    lduty = 8'hFF;
    pause();
    chk(chan, 8'h4C);
    $display("test generator routing done");
    m.xfer(fr(1'b1, ADDR_INRUSH, 8'h77) ^ 16'h0002, rx, 16);
    m.xfer(fr(1'b0, ADDR_IDENTITY, 8'h00), rx, 16);
    chk({7'h00, rx[15]}, 8'h01);
    rd(ADDR_INRUSH, 8'h00);
    m.xfer(fr(1'b1, ADDR_INRUSH, 8'h77), rx, 8);
    m.xfer(fr(1'b0, ADDR_IDENTITY, 8'h00), rx, 16);
    chk({7'h00, rx[15]}, 8'h01);
    rd(ADDR_INRUSH, 8'h00);
    $display("test frame refusal done");
    finish_test();
  end
endmodule // relay_driver_config_regs_tb_top
